// ==== icp_pkg.sv ====
// Purpose: Shared constants and types for the interrupt configuration block
// Assumes: 16-bit register port, word index addressing
// Notes: Register offsets are indices on the plain register port
`default_nettype none
package icp_pkg;
  localparam int unsigned ICP_AW = 2;
  localparam int unsigned ICP_DW = 16;
  localparam int unsigned ICP_NSRC = 13;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [1:0] ICP_OFF_CTL = 2'h0;
  localparam logic [1:0] ICP_OFF_IEM = 2'h1;
  localparam logic [1:0] ICP_OFF_IE3 = 2'h2;
  localparam logic [1:0] ICP_OFF_IPR = 2'h3;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned ICP_BIT_ALT = 15;
  localparam int unsigned ICP_BIT_DIS = 14;
  localparam int unsigned ICP_BIT_CAL = 14;
  localparam logic [15:0] ICP_CTL_WMASK = 16'h8007;
  localparam logic [15:0] ICP_IEM_MASK = 16'hbf8f;
  localparam logic [15:0] ICP_IE3_MASK = 16'h4000;
  localparam logic [15:0] ICP_IPR_MASK = 16'h7777;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] ICP_CTL_RST = 16'h0000;
  localparam logic [15:0] ICP_IEM_RST = 16'h0000;
  localparam logic [15:0] ICP_IE3_RST = 16'h0000;
  localparam logic [15:0] ICP_IPR_RST = 16'h4444;
  // Request presented to the core
  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic [2:0] level;
    logic alt_table;
  } icp_req_t;
endpackage : icp_pkg
`default_nettype wire

// ==== icp_ctrl.sv ====
// Purpose: Interrupt enable, priority, polarity and vector table control
// Assumes: Inputs synchronous to i_clk; request lines are levels from sources
// Notes: Source index: 0 ext0,1 capture,2 compare,3 timer_a,4 timer_b,5 timer_c,
//   6 spi_fault,7 spi_xfer,8 serial_rx,9 serial_tx,10 conv_done,11 nvm,12 calendar
// How it works
// RL1: Bit 15 of control selects the alternate vector table when set, else standard.
// RL2: Bit 14 of control is read-only and mirrors the timed disable instruction state.
// RL3: Control bits 0..2 pick negative edge (1) or positive edge (0) for external pins 0..2; only pin 0 feeds a source, pins 1..2 pend unused.
// RL4: A source request is only serviced while its enable bit is set.
// RL5: The main enable register maps the sources to bits 15,13..7,3..0 as listed.
// RL6: The calendar source is enabled by bit 14 of a separate register, other bits absent.
// RL7: Priority codes 111 down to 001 give levels 7 down to 1.
// RL8: A priority code of 000 disables its source whatever its enable bit.
// RL9: Priority register fields sit at 14-12, 10-8, 6-4 and 2-0 with gaps unused.
// RL10: Priority fields reset to 100 and enable and control bits reset to 0.
// RL11: Unimplemented bits ignore writes and read back 0.
// RL12: The highest-level enabled pending request is presented to the core.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none
module icp_ctrl #(
  parameter logic [2:0] FIXED_PRI = 3'h4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [icp_pkg::ICP_AW-1:0] i_addr,
  input wire logic [icp_pkg::ICP_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [icp_pkg::ICP_DW-1:0] o_rdata,
  input wire logic i_timed_disable_active,
  input wire logic [2:0] i_ext_pin,
  input wire logic [icp_pkg::ICP_NSRC-1:0] i_src_req,
  output icp_pkg::icp_req_t o_req
);
  import icp_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] ctl_r;
  logic [15:0] iem_r;
  logic [15:0] ie3_r;
  logic [15:0] ipr_r;
  logic [2:0] pin_r;
  logic [2:0] ext_pend_r;
  logic [15:0] rdata_r;
  icp_req_t req_r;

  wire wr_ctl = i_wr && (i_addr == ICP_OFF_CTL);
  wire wr_iem = i_wr && (i_addr == ICP_OFF_IEM);
  wire wr_ie3 = i_wr && (i_addr == ICP_OFF_IE3);
  wire wr_ipr = i_wr && (i_addr == ICP_OFF_IPR);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_r <= ICP_CTL_RST; // RL10
      iem_r <= ICP_IEM_RST; // RL10
      ie3_r <= ICP_IE3_RST; // RL10
      ipr_r <= ICP_IPR_RST; // RL10
    end else if (i_ce) begin
      if (wr_ctl) ctl_r <= i_wdata & ICP_CTL_WMASK; // RL11
      if (wr_iem) iem_r <= i_wdata & ICP_IEM_MASK; // RL5
      if (wr_ie3) ie3_r <= i_wdata & ICP_IE3_MASK; // RL6
      if (wr_ipr) ipr_r <= i_wdata & ICP_IPR_MASK; // RL9
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire [15:0] ctl_view = {ctl_r[15], i_timed_disable_active, ctl_r[13:0]}; // RL2
  wire [15:0] rd_mux = (i_addr == ICP_OFF_CTL) ? ctl_view :
                       (i_addr == ICP_OFF_IEM) ? iem_r :
                       (i_addr == ICP_OFF_IE3) ? ie3_r : ipr_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 16'h0000;
    end else if (i_ce) begin
      rdata_r <= i_rd ? rd_mux : 16'h0000;
    end
  end
  assign o_rdata = rdata_r;

  // ---------------------------------------------------------------
  // External pin edge detection
  // ---------------------------------------------------------------
  wire [2:0] neg_sel = ctl_r[2:0];
  wire [2:0] rise = i_ext_pin & ~pin_r;
  wire [2:0] fall = ~i_ext_pin & pin_r;
  wire [2:0] ext_edge = (neg_sel & fall) | (~neg_sel & rise); // RL3
  logic [2:0] taken_ext;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_r <= 3'h0;
      ext_pend_r <= 3'h0;
    end else if (i_ce) begin
      pin_r <= i_ext_pin;
      ext_pend_r <= (ext_pend_r & ~taken_ext) | ext_edge;
    end
  end

  // ---------------------------------------------------------------
  // Per-source enable and priority
  // ---------------------------------------------------------------
  logic [ICP_NSRC-1:0] en;
  logic [2:0] pri [ICP_NSRC];
  logic [ICP_NSRC-1:0] pend;
  assign en = {ie3_r[ICP_BIT_CAL], iem_r[15], iem_r[13:7], iem_r[3:0]}; // RL5 RL6
  assign pri[0] = ipr_r[2:0]; // RL9
  assign pri[1] = ipr_r[6:4];
  assign pri[2] = ipr_r[10:8];
  assign pri[3] = ipr_r[14:12];
  assign pend = {i_src_req[ICP_NSRC-1:1], ext_pend_r[0]};

  genvar g;
  generate
    for (g = 4; g < ICP_NSRC; g++) begin : g_fixed
      assign pri[g] = FIXED_PRI;
    end
  endgenerate

  // Live request: enabled, pending and nonzero level
  logic [ICP_NSRC-1:0] live;
  generate
    for (g = 0; g < ICP_NSRC; g++) begin : g_live
      assign live[g] = pend[g] && en[g] && (pri[g] != 3'h0); // RL4 RL8
    end
  endgenerate

  // ---------------------------------------------------------------
  // Highest level wins, lowest index breaks ties
  // ---------------------------------------------------------------
  logic [2:0] best_lvl;
  logic [3:0] best_src;
  logic best_v;
  always_comb begin
    best_lvl = 3'h0;
    best_src = 4'h0;
    best_v = 1'b0;
    for (int i = ICP_NSRC - 1; i >= 0; i--) begin
      if (live[i] && pri[i] >= best_lvl) begin // RL7 RL12
        best_lvl = pri[i];
        best_src = 4'(i);
        best_v = 1'b1;
      end
    end
  end
  assign taken_ext = {2'b00, best_v && best_src == 4'h0};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_r <= '0;
    end else if (i_ce) begin
      req_r.valid <= best_v;
      req_r.src <= best_src;
      req_r.level <= best_lvl;
      req_r.alt_table <= ctl_r[ICP_BIT_ALT]; // RL1
    end
  end
  assign o_req = req_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_alt;
    @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_req.alt_table == $past(ctl_r[15]);
  endproperty
  a_alt: assert property (p_alt) else $error("alt table bit mismatch"); // RL1

  property p_dis_rd;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_rd && i_addr == ICP_OFF_CTL) |=>
        o_rdata[14] == $past(i_timed_disable_active);
  endproperty
  a_dis_rd: assert property (p_dis_rd) else $error("disable status read wrong"); // RL2

  property p_edge;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ext_edge[0]) |=> ext_pend_r[0];
  endproperty
  a_edge: assert property (p_edge) else $error("ext0 edge lost"); // RL3

  property p_en;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && best_v) |-> en[best_src];
  endproperty
  a_en: assert property (p_en) else $error("disabled source presented"); // RL4

  property p_zero;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && best_v) |-> pri[best_src] != 3'h0 && best_lvl == pri[best_src];
  endproperty
  a_zero: assert property (p_zero) else $error("level zero source presented"); // RL8

  property p_max;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && live[3]) |-> best_v && best_lvl >= ipr_r[14:12];
  endproperty
  a_max: assert property (p_max) else $error("higher level not chosen"); // RL12

  property p_unimp;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_rd && i_addr == ICP_OFF_IPR) |=> (o_rdata & ~ICP_IPR_MASK) == 16'h0000;
  endproperty
  a_unimp: assert property (p_unimp) else $error("unused bits read nonzero"); // RL11

  property p_ie3;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_ie3) |=> ie3_r == ($past(i_wdata) & 16'h4000);
  endproperty
  a_ie3: assert property (p_ie3) else $error("calendar enable write wrong"); // RL6

  property p_ce_hold;
    @(posedge i_clk) disable iff (i_rst)
      !i_ce |=> $stable(ctl_r) && $stable(iem_r) && $stable(ie3_r) && $stable(ipr_r);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved while frozen"); // RL10

  property p_ce_req;
    @(posedge i_clk) disable iff (i_rst)
      !i_ce |=> $stable(o_req) && $stable(o_rdata);
  endproperty
  a_ce_req: assert property (p_ce_req) else $error("outputs moved while frozen"); // RL12

  property p_rd_idle;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_rd) |=> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot"); // RL11

  property p_ctl_mask;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_ctl) |=> ctl_r == ($past(i_wdata) & ICP_CTL_WMASK);
  endproperty
  a_ctl_mask: assert property (p_ctl_mask) else $error("control write wrong"); // RL11

  property p_ctl_ro;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_ctl) |=> ctl_r[ICP_BIT_DIS] == 1'b0;
  endproperty
  a_ctl_ro: assert property (p_ctl_ro) else $error("status bit written"); // RL2

  property p_iem_mask;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_iem) |=> iem_r == ($past(i_wdata) & ICP_IEM_MASK);
  endproperty
  a_iem_mask: assert property (p_iem_mask) else $error("main enable write wrong"); // RL5

  property p_ipr_mask;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_ipr) |=> ipr_r == ($past(i_wdata) & ICP_IPR_MASK);
  endproperty
  a_ipr_mask: assert property (p_ipr_mask) else $error("priority write wrong"); // RL9

  property p_neg;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && neg_sel[0] && pin_r[0] && !i_ext_pin[0]) |=> ext_pend_r[0];
  endproperty
  a_neg: assert property (p_neg) else $error("ext0 falling edge lost"); // RL3

  property p_pos;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !neg_sel[0] && !pin_r[0] && i_ext_pin[0]) |=> ext_pend_r[0];
  endproperty
  a_pos: assert property (p_pos) else $error("ext0 rising edge lost"); // RL3

  property p_lvl7;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && live[2] && ipr_r[10:8] == 3'h7) |-> best_v && best_lvl == 3'h7;
  endproperty
  a_lvl7: assert property (p_lvl7) else $error("level seven not on top"); // RL7

  property p_zero_src;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && ipr_r[2:0] == 3'h0) |-> !live[0];
  endproperty
  a_zero_src: assert property (p_zero_src) else $error("ext0 live at code zero"); // RL8

  property p_req_reg;
    @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_req.valid == $past(best_v) && o_req.level == $past(best_lvl);
  endproperty
  a_req_reg: assert property (p_req_reg) else $error("request not registered"); // RL12

  c_ce: cover property (@(posedge i_clk) disable iff (i_rst) !i_ce && i_wr);
  c_ext: cover property (@(posedge i_clk) disable iff (i_rst) o_req.valid && o_req.src == 4'h0);
  c_alt: cover property (@(posedge i_clk) disable iff (i_rst) o_req.alt_table);
  c_req: cover property (@(posedge i_clk) disable iff (i_rst) o_req.valid && o_req.level == 3'h7);
  c_neg: cover property (@(posedge i_clk) disable iff (i_rst) neg_sel[0] && ext_edge[0]);
endmodule : icp_ctrl
`default_nettype wire

// ==== icp_src_model.sv ====
// Purpose: Request sources and core side of the interrupt block
// Assumes: One clock
// Notes: Sources hold level requests, the core counts shown requests
`default_nettype none
module icp_src_model (
  input wire logic i_clk,
  input wire logic [12:0] i_set,
  input wire icp_pkg::icp_req_t i_req,
  output logic [12:0] o_src_req,
  output logic [15:0] o_seen
);
  import icp_pkg::*;
  logic [15:0] seen_r = 16'h0;
  assign o_src_req = i_set;
  always @(posedge i_clk) begin
    if (i_req.valid === 1'b1) begin
      seen_r <= seen_r + 16'h1;
    end
  end
  assign o_seen = seen_r;
endmodule : icp_src_model
`default_nettype wire

// ==== icp_ctrl_tb.sv ====
// Purpose: Self-checking bench for the interrupt block
// Assumes: Register port with one-cycle read data
// Notes: Register rows first, then source, priority and pin cases
`default_nettype none
module icp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import icp_pkg::*;
  logic clk, rst, wr, rd, dis, ce;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, v, seen;
  logic [2:0] pin;
  logic [12:0] set, src_req;
  icp_req_t req;
  int mismatches = 0;
  int checks_done = 0;
  int unsigned bmap [13] = '{0, 1, 2, 3, 7, 8, 9, 10, 11, 12, 13, 15, 0};
  logic [34:0] rows [8] = '{{1'b0, 2'h0, 16'h0, 16'h0000}, {1'b0, 2'h1, 16'h0, 16'h0000},
    {1'b0, 2'h2, 16'h0, 16'h0000}, {1'b0, 2'h3, 16'h0, 16'h4444},
    {1'b1, 2'h0, 16'hffff, 16'h8007}, {1'b1, 2'h1, 16'hffff, 16'hbf8f},
    {1'b1, 2'h2, 16'hffff, 16'h4000}, {1'b1, 2'h3, 16'hffff, 16'h7777}};
  icp_ctrl u_icp_ctrl (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timed_disable_active(dis), .i_ext_pin(pin),
    .i_src_req(src_req), .o_req(req));
  icp_src_model u_icp_src_model (.i_clk(clk), .i_set(set), .i_req(req), .o_src_req(src_req),
    .o_seen(seen));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n = "req");
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic wait2();
    repeat (2) @(posedge clk);
    #1;
  endtask : wait2
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {wr, rd, dis, addr, wdata, pin, set} = '0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][34]) begin
        wr_reg(rows[i][33:32], rows[i][31:16]);
      end
      rd_reg(rows[i][33:32]);
      chk(v, rows[i][15:0], "reg");
    end
    dis <= 1'b1;
    wr_reg(ICP_OFF_CTL, 16'h0);
    rd_reg(ICP_OFF_CTL);
    chk(v, 16'h4000, "ctl_dis");
    dis <= 1'b0;
    rd_reg(ICP_OFF_CTL);
    chk(v, 16'h0000, "ctl_idle");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_reg(ICP_OFF_IPR);
    chk(v, 16'h4444, "ipr_rst");
    chk({7'h0, req}, 16'h0000, "req_rst");
    for (int k = 1; k < 13; k++) begin
      wr_reg(ICP_OFF_IEM, (k < 12) ? (16'h1 << bmap[k]) : 16'h0);
      wr_reg(ICP_OFF_IE3, (k == 12) ? 16'h4000 : 16'h0);
      set <= 13'h1 << k;
      wait2();
      chk({7'h0, req}, {7'h0, 1'b1, k[3:0], 3'h4, 1'b0});
      wr_reg(ICP_OFF_IEM, 16'h0);
      wr_reg(ICP_OFF_IE3, 16'h0);
      wait2();
      chk({15'h0, req.valid}, 16'h0, "valid");
    end
    wr_reg(ICP_OFF_CTL, 16'h8000);
    wr_reg(ICP_OFF_IEM, 16'h000e);
    wr_reg(ICP_OFF_IPR, 16'h1730);
    set <= 13'h000e;
    wait2();
    chk({7'h0, req}, {7'h0, 1'b1, 4'h2, 3'h7, 1'b1});
    wr_reg(ICP_OFF_IPR, 16'h1030);
    wait2();
    chk({7'h0, req}, {7'h0, 1'b1, 4'h1, 3'h3, 1'b1});
    wr_reg(ICP_OFF_IPR, 16'h1000);
    wait2();
    chk({7'h0, req}, {7'h0, 1'b1, 4'h3, 3'h1, 1'b1});
    set <= 13'h0;
    wr_reg(ICP_OFF_CTL, 16'h0);
    wr_reg(ICP_OFF_IEM, 16'h0001);
    wr_reg(ICP_OFF_IPR, 16'h0004);
    pin <= 3'h1;
    wait2();
    chk({7'h0, req}, {7'h0, 1'b1, 4'h0, 3'h4, 1'b0});
    wr_reg(ICP_OFF_CTL, 16'h0001);
    pin <= 3'h0;
    wait2();
    chk({7'h0, req}, {7'h0, 1'b1, 4'h0, 3'h4, 1'b0});
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(ICP_OFF_IPR, 16'h7777);
    ce <= 1'b1;
    rd_reg(ICP_OFF_IPR);
    chk(v, 16'h0004, "ce_hold");
    chk({15'h0, seen != 16'h0}, 16'h1, "seen");
    end_sim();
  end
endmodule : icp_ctrl_tb
`default_nettype wire
